/* core/dts_defines.svh */
// register map, field positions, reset values and level constants
`ifndef DTS_DEFINES_SVH
`define DTS_DEFINES_SVH

// register byte offsets
`define A_TBASE   8'h00
`define A_DTRIG   8'h04
`define A_DELAY   8'h08
`define A_EVENTS  8'h0C
`define A_LEVEL   8'h10
`define A_PRESET  8'h14
`define A_SCALE   8'h18
`define A_RECLEN  8'h1C
`define A_STATUS  8'h20
`define A_ZONE    8'h24

// time base register fields
`define TB_MODE   0
`define TB_EN     1
// delayed trigger register fields
`define DT_CRIT   1:0
`define DT_SRC    4:2
`define DT_CPL    6:5
`define DT_SLOPE  7
// record length register fields
`define RL_POST   15:0
`define RL_MAIN   31:16
// status register fields
`define ST_TRIG   0
`define ST_COMPAT 1
`define ST_REJ    2
`define ST_STATE  7:3
`define ST_TAND   8
// generic 16-bit value field, preset code field and zone start and end fields
`define F_VAL     15:0
`define F_PRESET  1:0
`define F_ZSTART  15:0
`define F_ZEND    31:16

// reset values
`define RST_DELAY   16'h0010
`define RST_EVENTS  16'h0001
`define RST_LEVEL   16'sh0000
`define RST_SCALE   16'h00C8
`define RST_POST    16'h0100
`define RST_MAIN    16'h0400

// level presets in millivolts, clamp span in divisions
`define LVL_TTL     16'sh0578
`define LVL_ECL     16'shFAEC
`define CLAMP_DIVS  22'sh00000C

`endif

/* core/dts_pkg.sv */
// types shared by the delayed trigger sequencer
package dts_pkg;

   typedef enum logic [4:0] {
      S_WAIT = 5'h01,
      S_TIME = 5'h02,
      S_EVT  = 5'h04,
      S_TRIG = 5'h08,
      S_POST = 5'h10
   } seq_state_t;

   typedef enum logic [1:0] {
      CRIT_TIME        = 2'h0,
      CRIT_EVENTS      = 2'h1,
      CRIT_EVENTS_TIME = 2'h2
   } crit_t;

   typedef enum logic [2:0] {
      SRC_INPUT_CHANNEL_ONE    = 3'h0,
      SRC_INPUT_CHANNEL_TWO    = 3'h1,
      SRC_INPUT_CHANNEL_THREE  = 3'h2,
      SRC_INPUT_CHANNEL_FOUR   = 3'h3,
      SRC_AUXILIARY_DC_INPUT   = 3'h4
   } src_t;

   typedef enum logic [1:0] {
      SEL_FOLLOW_MAIN = 2'h0,
      SEL_DC          = 2'h1,
      SEL_NOISE_REJ   = 2'h2
   } cpl_sel_t;

   typedef enum logic [1:0] {
      CPL_DC        = 2'h0,
      CPL_NOISE_REJ = 2'h1,
      CPL_AC        = 2'h2,
      CPL_HF_REJ    = 2'h3
   } coupling_t;

   typedef enum logic [1:0] {
      TYPE_EDGE  = 2'h0,
      TYPE_PULSE = 2'h1,
      TYPE_LOGIC = 2'h2
   } main_type_t;

   typedef enum logic [1:0] {
      CLASS_GLITCH = 2'h0,
      CLASS_WIDTH  = 2'h1,
      CLASS_RUNT   = 2'h2,
      CLASS_SLEW   = 2'h3
   } main_class_t;

   typedef enum logic [1:0] {
      PRESET_NONE = 2'h0,
      PRESET_TTL  = 2'h1,
      PRESET_ECL  = 2'h2,
      PRESET_HALF = 2'h3
   } preset_t;

   typedef struct packed {
      logic               trig_mode;
      logic               enable;
      crit_t              crit;
      src_t               src;
      cpl_sel_t           cpl_sel;
      logic               slope;
      logic [15:0]        delay;
      logic [15:0]        events;
      logic signed [15:0] level;
      logic [15:0]        scale;
      logic [15:0]        post_len;
      logic [15:0]        main_len;
      logic               rejected;
      seq_state_t         st;
      logic               run_trig;
      crit_t              run_crit;
      logic [15:0]        cnt;
      logic [4:0]         sync1;
      logic [4:0]         sync2;
      logic               samp;
      logic               filt;
      logic               lvl_prev;
      logic [31:0]        prdata;
      logic               slverr;
      logic               acq_start;
      logic               rec_ready;
      logic signed [15:0] mlvl;
      logic               mlvl_wr;
      logic [15:0]        zone_start;
      logic [15:0]        zone_end;
      logic               trig_eff;
      coupling_t          cpl_eff;
   } regs_t;

endpackage

/* core/delayed_trigger_sequencer.sv */
// delayed time base sequencer with apb register file
//
// Contract
// R1: runs-after mode waits main trigger, counts delay, then starts record unqualified.
// R2: only triggerable mode uses the delayed trigger edge logic.
// R3: triggerable mode applies one criterion: time, events, or events then time.
// R4: pretrigger capture runs always; after criteria, count posttrigger, flag ready.
// R5: logic type, runt or slew class force runs-after mode.
// R6: auxiliary main source is incompatible with triggerable mode.
// R7: selecting triggerable mode while incompatible is rejected.
// R8: writing a delay criterion switches to triggerable; only time base leaves it.
// R9: delayed source is one of four channels or auxiliary dc input.
// R10: both sources auxiliary: level change on either updates both.
// R11: coupling follow-main, dc or noise reject; follow copies main coupling.
// R12: delayed trigger qualifies on rising or falling slope.
// R13: runs-after zone spans delayed record start to its end.
// R14: triggerable zone spans earliest delayed start to end of main record.
// R15: events-and-time keeps separate delay time and event count settings.
// R16: ttl preset gives +1.4 V, ecl preset gives -1.3 V, then clamped.
// R17: fifty percent preset gives half the source peak-to-peak value.
// R18: level clamped to twelve vertical divisions either side of center.
// R19: events criterion counts slope edges, accepts trigger at programmed count.
// R20: after each delayed record the sequencer waits for next main trigger.
`include "dts_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module delayed_trigger_sequencer
(
   // clock, reset, enable
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 ce,
   // apb slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   // main trigger logic
   input  wire logic                 main_trig,
   input  wire dts_pkg::main_type_t  main_type,
   input  wire dts_pkg::main_class_t main_class,
   input  wire dts_pkg::src_t        main_source,
   input  wire dts_pkg::coupling_t   main_coupling,
   input  wire logic signed [15:0]   main_level,
   input  wire logic                 main_level_set,
   output logic signed [15:0]        main_level_out,
   output logic                      main_level_wr,
   // delayed source comparators and measurement
   input  wire logic [4:0]           src_raw,
   input  wire logic [15:0]          src_pk2pk,
   // front end and acquisition record
   output dts_pkg::coupling_t        dly_coupling,
   output logic signed [15:0]        dly_level,
   output logic                      triggerable,
   output logic                      acq_start,
   output logic                      post_active,
   output logic                      rec_ready,
   output logic [15:0]               zone_start,
   output logic [15:0]               zone_end
);
   import dts_pkg::*;

   localparam regs_t REGS_RST = '{
      default:  '0,
      crit:     CRIT_TIME,
      src:      SRC_INPUT_CHANNEL_ONE,
      cpl_sel:  SEL_FOLLOW_MAIN,
      st:       S_WAIT,
      run_crit: CRIT_TIME,
      cpl_eff:  CPL_DC,
      delay:    `RST_DELAY,
      events:   `RST_EVENTS,
      level:    `RST_LEVEL,
      scale:    `RST_SCALE,
      post_len: `RST_POST,
      main_len: `RST_MAIN
   };

   regs_t q;
   regs_t d;

   logic        compat;
   logic        tandem;
   logic        noise;
   logic        lvl_now;
   logic        edge_hit;
   logic        mapped;
   logic        setup;
   logic        wr;
   logic [15:0] ev_goal;

   // R18: clamp to twelve divisions of the source scale
   function automatic logic signed [15:0] clamp_lvl(
      input logic signed [15:0] v,
      input logic [15:0]        scale);
      logic signed [21:0] lim;
      logic signed [21:0] vx;
      lim = $signed({6'h00, scale}) * `CLAMP_DIVS;
      vx  = 22'(v);
      if (vx > lim)
         return 16'(lim);
      else if (vx < -lim)
         return 16'(-lim);
      else
         return v;
   endfunction

   function automatic logic [31:0] rd_word(input logic [7:0] a,
                                           input regs_t r,
                                           input logic cmp,
                                           input logic tnd);
      logic [31:0] w;
      w = '0;
      case (a)
         `A_TBASE:
         begin
            w[`TB_MODE] = r.trig_mode;
            w[`TB_EN]   = r.enable;
         end
         `A_DTRIG:
         begin
            w[`DT_CRIT]  = r.crit;
            w[`DT_SRC]   = r.src;
            w[`DT_CPL]   = r.cpl_sel;
            w[`DT_SLOPE] = r.slope;
         end
         `A_DELAY:  w[`F_VAL] = r.delay;
         `A_EVENTS: w[`F_VAL] = r.events;
         `A_LEVEL:  w[`F_VAL] = r.level;
         `A_SCALE:  w[`F_VAL] = r.scale;
         `A_RECLEN:
         begin
            w[`RL_POST] = r.post_len;
            w[`RL_MAIN] = r.main_len;
         end
         `A_STATUS:
         begin
            w[`ST_TRIG]   = r.trig_eff;
            w[`ST_COMPAT] = cmp;
            w[`ST_REJ]    = r.rejected;
            w[`ST_STATE]  = r.st;
            w[`ST_TAND]   = tnd;
         end
         `A_ZONE:
         begin
            w[`F_ZSTART] = r.zone_start;
            w[`F_ZEND]   = r.zone_end;
         end
         default: w = '0;
      endcase
      return w;
   endfunction

   // R5 R6: main settings that allow triggerable mode
   assign compat = (main_type != TYPE_LOGIC)
                 && !(main_type == TYPE_PULSE
                      && (main_class == CLASS_RUNT
                          || main_class == CLASS_SLEW))
                 && (main_source != SRC_AUXILIARY_DC_INPUT);

   // R10: shared auxiliary source ties both levels
   assign tandem = (main_source == SRC_AUXILIARY_DC_INPUT)
                 && (q.src == SRC_AUXILIARY_DC_INPUT);

   assign noise   = (q.cpl_eff == CPL_NOISE_REJ);
   assign lvl_now = noise ? q.filt : q.samp;

   // R12: slope select on the qualified source level
   assign edge_hit = q.slope ? (q.lvl_prev & ~lvl_now)
                             : (~q.lvl_prev & lvl_now);

   assign ev_goal = (q.events == '0) ? 16'h0001 : q.events;

   assign mapped = (paddr == `A_TBASE) || (paddr == `A_DTRIG)
                || (paddr == `A_DELAY) || (paddr == `A_EVENTS)
                || (paddr == `A_LEVEL) || (paddr == `A_PRESET)
                || (paddr == `A_SCALE) || (paddr == `A_RECLEN)
                || (paddr == `A_STATUS) || (paddr == `A_ZONE);

   assign setup = psel & ~penable;
   assign wr    = psel & penable & pwrite & ce;

   always_comb
   begin
      logic rej_set;
      logic rej_clr;
      logic lvl_chg;
      logic go_post;
      rej_set = 1'b0;
      rej_clr = 1'b0;
      lvl_chg = 1'b0;
      go_post = 1'b0;
      d = q;
      if (ce)
      begin
         d.acq_start = 1'b0;
         d.rec_ready = 1'b0;
         d.mlvl_wr   = 1'b0;

         // R9: two-stage sync, then select the delayed source
         d.sync1 = src_raw;
         d.sync2 = q.sync1;
         d.samp  = q.sync2[q.src];
         // R11: noise reject needs two agreeing samples
         if (q.sync2[q.src] == q.samp)
            d.filt = q.samp;
         d.lvl_prev = lvl_now;

         // R10: main level change follows into delayed level
         if (tandem && main_level_set)
            d.level = clamp_lvl(main_level, q.scale);

         if (setup)
         begin
            d.prdata = rd_word(paddr, q, compat, tandem);
            d.slverr = ~mapped;
         end

         if (wr && mapped)
         begin
            case (paddr)
               `A_TBASE:
               begin
                  d.enable = pwdata[`TB_EN];
                  // R7: refuse triggerable while main is incompatible
                  if (pwdata[`TB_MODE] && !compat)
                  begin
                     d.trig_mode = 1'b0;
                     rej_set     = 1'b1;
                  end
                  else
                     d.trig_mode = pwdata[`TB_MODE];
               end
               `A_DTRIG:
               begin
                  d.crit    = crit_t'(pwdata[`DT_CRIT]);
                  d.src     = src_t'(pwdata[`DT_SRC]);
                  d.cpl_sel = cpl_sel_t'(pwdata[`DT_CPL]);
                  d.slope   = pwdata[`DT_SLOPE];
                  // R8: criterion write selects triggerable mode
                  if (compat)
                     d.trig_mode = 1'b1;
                  else
                     rej_set = 1'b1;
               end
               // R15: delay and event count held apart
               `A_DELAY:  d.delay  = pwdata[`F_VAL];
               `A_EVENTS: d.events = pwdata[`F_VAL];
               `A_LEVEL:
               begin
                  d.level = clamp_lvl($signed(pwdata[`F_VAL]), q.scale);
                  lvl_chg = 1'b1;
               end
               `A_PRESET:
               begin
                  lvl_chg = 1'b1;
                  unique case (preset_t'(pwdata[`F_PRESET]))
                     // R16: logic family presets
                     PRESET_TTL: d.level = clamp_lvl(`LVL_TTL, q.scale);
                     PRESET_ECL: d.level = clamp_lvl(`LVL_ECL, q.scale);
                     // R17: half of the measured peak-to-peak
                     PRESET_HALF:
                        d.level = clamp_lvl($signed({1'b0, src_pk2pk[15:1]}),
                                            q.scale);
                     PRESET_NONE: lvl_chg = 1'b0;
                  endcase
               end
               `A_SCALE:
               begin
                  d.scale = pwdata[`F_VAL];
                  d.level = clamp_lvl(q.level, pwdata[`F_VAL]);
                  lvl_chg = 1'b1;
               end
               `A_RECLEN:
               begin
                  d.post_len = pwdata[`RL_POST];
                  d.main_len = pwdata[`RL_MAIN];
               end
               `A_STATUS: rej_clr = pwdata[`ST_REJ];
               default: rej_clr = 1'b0;
            endcase
         end

         // a new rejection wins over a clear in the same cycle
         d.rejected = rej_set | (q.rejected & ~rej_clr);

         // R10: delayed level change pushed to the main system
         if (lvl_chg && tandem)
         begin
            d.mlvl    = d.level;
            d.mlvl_wr = 1'b1;
         end

         unique case (q.st)
            S_WAIT:
            begin
               if (q.enable && main_trig)
               begin
                  // R2 R5: mode latched at the main trigger
                  d.run_trig = q.trig_eff;
                  d.run_crit = q.crit;
                  // R1 R3: time first, or event count first
                  if (!q.trig_eff || q.crit == CRIT_TIME)
                  begin
                     d.st  = S_TIME;
                     d.cnt = q.delay;
                  end
                  else
                  begin
                     d.st  = S_EVT;
                     d.cnt = '0;
                  end
               end
            end
            S_TIME:
            begin
               if (q.cnt == '0)
               begin
                  // R1: runs-after starts with no qualification
                  if (!q.run_trig)
                     go_post = 1'b1;
                  else
                     d.st = S_TRIG;
               end
               else
                  d.cnt = q.cnt - 16'h0001;
            end
            S_EVT:
            begin
               // R19: count slope edges up to the programmed count
               if (edge_hit)
               begin
                  if ({1'b0, q.cnt} + 17'h00001 >= {1'b0, ev_goal})
                  begin
                     if (q.run_crit == CRIT_EVENTS)
                        go_post = 1'b1;
                     else
                     begin
                        d.st  = S_TIME;
                        d.cnt = q.delay;
                     end
                  end
                  else
                     d.cnt = q.cnt + 16'h0001;
               end
            end
            S_TRIG:
            begin
               if (edge_hit)
                  go_post = 1'b1;
            end
            S_POST:
            begin
               // R4 R20: finish record, flag it, rearm
               if (q.cnt == '0)
               begin
                  d.rec_ready = 1'b1;
                  d.st        = S_WAIT;
               end
               else
                  d.cnt = q.cnt - 16'h0001;
            end
            default: d.st = S_WAIT;
         endcase

         // R4: posttrigger count for the delayed record
         if (go_post)
         begin
            d.st        = S_POST;
            d.cnt       = q.post_len;
            d.acq_start = 1'b1;
         end
         if (!q.enable)
            d.st = S_WAIT;

         // R5 R6: forced runs-after while main is incompatible
         d.trig_eff = q.trig_mode & compat;
         // R11: follow-main copies main coupling
         unique case (q.cpl_sel)
            SEL_DC:        d.cpl_eff = CPL_DC;
            SEL_NOISE_REJ: d.cpl_eff = CPL_NOISE_REJ;
            default:       d.cpl_eff = main_coupling;
         endcase

         d.zone_start = q.delay;
         // R14: triggerable zone runs to end of main record
         if (q.trig_eff)
            d.zone_end = q.main_len;
         // R13: runs-after zone covers the delayed record
         else
            d.zone_end = 16'(q.delay + q.post_len);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= REGS_RST;
      else
         q <= d;
   end

   assign prdata         = q.prdata;
   assign pslverr        = q.slverr;
   assign pready         = psel & penable & ce;
   assign main_level_out = q.mlvl;
   assign main_level_wr  = q.mlvl_wr;
   assign dly_coupling   = q.cpl_eff;
   assign dly_level      = q.level;
   assign triggerable    = q.trig_eff;
   assign acq_start      = q.acq_start;
   assign post_active    = (q.st == S_POST);
   assign rec_ready      = q.rec_ready;
   assign zone_start     = q.zone_start;
   assign zone_end       = q.zone_end;

endmodule

`default_nettype wire

/* tb/dts_properties.sv */
// sequencer port assertions
`timescale 1ns/1ns
`default_nettype none
module dts_properties
(
   // clock, reset, enable
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 ce,
   // main trigger settings
   input wire dts_pkg::main_type_t  main_type,
   input wire dts_pkg::main_class_t main_class,
   input wire dts_pkg::src_t        main_source,
   // level push
   input wire logic signed [15:0]   main_level_out,
   input wire logic                 main_level_wr,
   input wire logic signed [15:0]   dly_level,
   // sequencer
   input wire logic                 triggerable,
   input wire logic                 acq_start,
   input wire logic                 post_active,
   input wire logic                 rec_ready
);
   import dts_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_logic;
      ce && main_type == TYPE_LOGIC;
   endsequence
   sequence s_slow;
      ce && main_type == TYPE_PULSE
         && (main_class == CLASS_RUNT || main_class == CLASS_SLEW);
   endsequence
   sequence s_aux;
      ce && main_source == SRC_AUXILIARY_DC_INPUT;
   endsequence
   sequence s_start;
      ce && acq_start;
   endsequence
   sequence s_done;
      ce && $rose(rec_ready);
   endsequence
   AST_LOGIC_RUNS:
      assert property (s_logic [*3] |-> !triggerable)
      else $error("logic type triggerable");
   AST_CLASS_RUNS:
      assert property (s_slow [*3] |-> !triggerable)
      else $error("class triggerable");
   AST_AUX_RUNS:
      assert property (s_aux [*3] |-> !triggerable)
      else $error("aux triggerable");
   AST_START_PULSE:
      assert property (s_start |=> !acq_start)
      else $error("long start");
   AST_START_POST:
      assert property (s_start |=> post_active)
      else $error("no post count");
   AST_READY_AFTER_POST:
      assert property (s_done |-> $past(post_active))
      else $error("ready without post");
   AST_READY_PULSE:
      assert property (rec_ready && ce |=> !rec_ready)
      else $error("long ready");
   AST_READY_NOT_POST:
      assert property (!(rec_ready && post_active))
      else $error("ready in post");
   AST_TANDEM_PUSH:
      assert property (main_level_wr |-> main_level_out == dly_level)
      else $error("pushed level differs");
endmodule
bind delayed_trigger_sequencer dts_properties chk_u (.pclk, .presetn,
   .ce, .main_type, .main_class, .main_source, .main_level_out,
   .main_level_wr, .dly_level, .triggerable, .acq_start, .post_active,
   .rec_ready);
`default_nettype wire

/* tb/main_side_model.sv */
// main trigger side model
`timescale 1ns/1ns
`default_nettype none
module main_side_model
(
   // clock
   input wire logic          pclk,
   // main trigger
   output logic              main_trig,
   output logic signed [15:0] main_level,
   output logic              main_level_set,
   // delayed sources
   output logic [4:0]        src_raw,
   output logic [15:0]       src_pk2pk
);
   initial
   begin
      main_trig = 1'b0;
      main_level = 16'sh0000;
      main_level_set = 1'b0;
      src_raw = 5'h00;
      src_pk2pk = 16'h0800;
   end
   task fire;
      @(posedge pclk);
      main_trig <= 1'b1;
      @(posedge pclk);
      main_trig <= 1'b0;
   endtask
   task set_level(input logic signed [15:0] v);
      @(posedge pclk);
      main_level <= v;
      main_level_set <= 1'b1;
      @(posedge pclk);
      main_level_set <= 1'b0;
   endtask
   task flip(input int b);
      @(posedge pclk);
      src_raw[b] <= ~src_raw[b];
   endtask
endmodule
`default_nettype wire

/* tb/delayed_trigger_sequencer_tb.sv */
// bench for the delayed trigger sequencer
`timescale 1ns/1ns
`include "dts_defines.svh"
`default_nettype none
module delayed_trigger_sequencer_tb;
   import dts_pkg::*;
   logic               pclk, presetn, ce, psel, penable, pwrite;
   logic               pready, pslverr, err, main_trig, main_level_set;
   logic               main_level_wr, triggerable, acq_start;
   logic               post_active, rec_ready;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, q;
   main_type_t         main_type;
   main_class_t        main_class;
   src_t               main_source;
   coupling_t          main_coupling, dly_coupling;
   logic signed [15:0] main_level, main_level_out, dly_level;
   logic [4:0]         src_raw;
   logic [15:0]        src_pk2pk, zone_start, zone_end, lvl_out;
   int                 failures, cmp_count, acq_n, a0, n, k;
   logic [7:0]  ra[5] = '{`A_TBASE, `A_DELAY, `A_EVENTS, `A_SCALE, `A_RECLEN};
   logic [31:0] rv[5] = '{32'h0, 32'h10, 32'h1, 32'hC8, 32'h04000100};
   main_type_t  bt[5] = '{TYPE_LOGIC, TYPE_PULSE, TYPE_PULSE, TYPE_EDGE,
                          TYPE_PULSE};
   main_class_t bc[5] = '{CLASS_GLITCH, CLASS_RUNT, CLASS_SLEW,
                          CLASS_GLITCH, CLASS_WIDTH};
   src_t        bs[5] = '{SRC_INPUT_CHANNEL_ONE, SRC_INPUT_CHANNEL_ONE,
                          SRC_INPUT_CHANNEL_ONE, SRC_AUXILIARY_DC_INPUT,
                          SRC_INPUT_CHANNEL_ONE};
   logic [31:0] bx[5] = '{32'h4, 32'h4, 32'h4, 32'h4, 32'h3};
   logic [31:0] dv[6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h20, 32'h40};
   coupling_t   mc[6] = '{CPL_DC, CPL_NOISE_REJ, CPL_AC, CPL_HF_REJ,
                          CPL_HF_REJ, CPL_HF_REJ};
   coupling_t   ec[6] = '{CPL_DC, CPL_NOISE_REJ, CPL_AC, CPL_HF_REJ,
                          CPL_DC, CPL_NOISE_REJ};
   logic [31:0] sc[5] = '{32'hC8, 32'hC8, 32'h64, 32'h64, 32'h64};
   logic [31:0] pc[5] = '{32'h1, 32'h2, 32'h1, 32'h2, 32'h3};
   logic [15:0] el[5] = '{16'h0578, 16'hFAEC, 16'h04B0, 16'hFB50, 16'h0400};

   delayed_trigger_sequencer dut_u (.pclk, .presetn, .ce, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .main_trig,
      .main_type, .main_class, .main_source, .main_coupling, .main_level,
      .main_level_set, .main_level_out, .main_level_wr, .src_raw,
      .src_pk2pk, .dly_coupling, .dly_level, .triggerable, .acq_start,
      .post_active, .rec_ready, .zone_start, .zone_end);
   main_side_model far_u (.pclk, .main_trig, .main_level, .main_level_set,
      .src_raw, .src_pk2pk);

   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      if (acq_start === 1'b1)
         acq_n <= acq_n + 1;
      if (main_level_wr === 1'b1)
         lvl_out <= main_level_out;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wt(input int c);
      repeat (c) @(negedge pclk);
   endtask
   task conclude;
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      {ce, psel, penable, pwrite, paddr, pwdata} = '0;
      ce = 1'b1;
      main_type = TYPE_EDGE;
      main_class = CLASS_GLITCH;
      main_source = SRC_INPUT_CHANNEL_ONE;
      main_coupling = CPL_DC;
      {failures, cmp_count, acq_n, lvl_out} = '0;
      presetn = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b0, ra[i], 32'h0);
         chk(q, rv[i]);
      end
      apb(1'b0, 8'h28, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, `A_DELAY, 32'h3);
      apb(1'b1, `A_EVENTS, 32'h2);
      apb(1'b1, `A_RECLEN, 32'h04000004);
      apb(1'b0, `A_DELAY, 32'h0);
      chk(q, 32'h3);
      apb(1'b0, `A_EVENTS, 32'h0);
      chk(q, 32'h2);
      apb(1'b1, `A_TBASE, 32'h2);
      far_u.fire();
      n = 0;
      while (acq_start !== 1'b1 && n < 100)
      begin
         @(negedge pclk);
         n++;
      end
      chk(32'(n), 32'h5);
      chk({31'h0, triggerable}, 32'h0);
      chk({zone_end, zone_start}, 32'h00070003);
      {n, k} = '0;
      while (rec_ready !== 1'b1 && k < 100)
      begin
         @(negedge pclk);
         k++;
         if (post_active === 1'b1)
            n++;
      end
      chk(32'(n), 32'h4);
      for (int i = 0; i < 5; i++)
      begin
         main_type <= bt[i];
         main_class <= bc[i];
         main_source <= bs[i];
         wt(3);
         apb(1'b1, `A_TBASE, 32'h3);
         apb(1'b0, `A_STATUS, 32'h0);
         chk(q & 32'h7, bx[i]);
         apb(1'b1, `A_STATUS, 32'h4);
      end
      for (int i = 0; i < 6; i++)
      begin
         main_coupling <= mc[i];
         apb(1'b1, `A_DTRIG, dv[i]);
         wt(2);
         chk(32'(dly_coupling), 32'(ec[i]));
      end
      chk({31'h0, triggerable}, 32'h1);
      apb(1'b1, `A_TBASE, 32'h2);
      wt(2);
      chk({31'h0, triggerable}, 32'h0);
      for (int s = 0; s < 2; s++)
      begin
         apb(1'b1, `A_DTRIG, 32'h05 | 32'(s << 7));
         a0 = acq_n;
         far_u.fire();
         for (int e = 0; e < 4; e++)
         begin
            far_u.flip(1);
            wt(10);
            if (e == 2)
               chk(32'(acq_n - a0), 32'(s == 0));
         end
         chk(32'(acq_n - a0), 32'h1);
      end
      chk({zone_end, zone_start}, 32'h04000003);
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b1, `A_SCALE, sc[i]);
         apb(1'b1, `A_PRESET, pc[i]);
         wt(2);
         chk({16'h0, dly_level}, {16'h0, el[i]});
      end
      main_source <= SRC_AUXILIARY_DC_INPUT;
      apb(1'b1, `A_DTRIG, 32'h10);
      apb(1'b1, `A_LEVEL, 32'h0100);
      wt(2);
      chk({16'h0, lvl_out}, 32'h0100);
      far_u.set_level(16'sh0200);
      wt(3);
      chk({16'h0, dly_level}, 32'h0200);
      apb(1'b1, `A_LEVEL, 32'h7FFF);
      wt(2);
      chk({16'h0, dly_level}, 32'h04B0);
      conclude();
   end
   initial
   begin
      repeat (20000) @(posedge pclk);
      failures++;
      conclude();
   end
endmodule
`default_nettype wire
